// file: bench/tiq_core_model.sv
// Core stand-in: timer sources, halt events and interrupt acknowledges
`timescale 1ns/10ps
module tiq_core_model
    import tiq_pkg::*;
#(
    parameter int ACK_DELAY = 3
)
(
    input wire logic clk_sys_in, // System clock
    input wire logic ack_en_in, // Acknowledge timer vectors
    input wire logic irq_valid_in, // Winner present
    input wire logic [7:0] irq_vector_in, // Winner vector
    output logic [2:0] timer_event_out, // Timer request pulses
    output logic [2:0] timer_ack_out, // Timer acknowledge pulses
    output logic nmi_out, // Non-maskable pulse
    output logic interrupt_return_instruction_out // Interrupt return pulse
);
    initial
    begin
        timer_event_out = 3'h0;
        timer_ack_out = 3'h0;
        nmi_out = 1'b0;
        interrupt_return_instruction_out = 1'b0;
    end
    // Slow service on purpose, so a stale winner would be seen
    always @(posedge clk_sys_in)
    begin
        timer_ack_out <= 3'h0;
        if (ack_en_in && irq_valid_in && timer_ack_out == 3'h0)
        begin
            repeat (ACK_DELAY) @(posedge clk_sys_in);
            timer_ack_out <= {irq_vector_in == 8'h13, irq_vector_in == 8'h12,
                              irq_vector_in == 8'h08};
        end
    end
    task automatic pulse(input logic [2:0] ev, input logic nmi, input logic interrupt_return_instruction);
        @(posedge clk_sys_in);
        timer_event_out <= ev;
        nmi_out <= nmi;
        interrupt_return_instruction_out <= interrupt_return_instruction;
        @(posedge clk_sys_in);
        timer_event_out <= 3'h0;
        nmi_out <= 1'b0;
        interrupt_return_instruction_out <= 1'b0;
    endtask : pulse
endmodule : tiq_core_model

// file: bench/tiq_irq_ctrl_test.sv
// Self-checking bench for the timer and DMA interrupt control block
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
    $display("unexpected at %0t got %h exp %h", $time, (a), (e)); end end
module tiq_irq_ctrl_test;
    import tiq_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, slave = 1'b0, ack_en = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [1:0] htrans = 2'h0, pin = 2'h0, pin_irq = 2'h0, dma_done = 2'h0, dma_req;
    logic ser_en = 1'b0, wd = 1'b0, hready, hresp, susp, irq_valid, nmi, interrupt_return_instruction;
    logic [5:0] ser = 6'h00;
    logic [4:0] ext = 5'h00, src_req;
    logic [2:0] tev, tack, irq_prio;
    logic [14:0] src_prio;
    logic [7:0] vec;
    int mismatches = 0, n_tests = 0;
    always #50 clk = ~clk;
    tiq_irq_ctrl dut (.clk_sys_in(clk), .nrst_in(nrst), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hready),
        .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .slave_mode_in(slave), .timer_event_in(tev), .timer_ack_in(tack), .nmi_in(nmi),
        .interrupt_return_instruction_in(interrupt_return_instruction), .shared_pin_in(pin), .pin_is_irq_in(pin_irq), .dma_done_in(dma_done),
        .serial_irq_enable_in(ser_en), .serial_src_in(ser), .watchdog_req_in(wd),
        .ext_line_req_in(ext), .dma_request_out(dma_req), .dma_suspend_out(susp),
        .src_req_out(src_req), .src_prio_out(src_prio), .irq_valid_out(irq_valid),
        .irq_vector_out(vec), .irq_prio_out(irq_prio));
    tiq_core_model #(.ACK_DELAY(3)) core (.clk_sys_in(clk), .ack_en_in(ack_en),
        .irq_valid_in(irq_valid), .irq_vector_in(vec), .timer_event_out(tev),
        .timer_ack_out(tack), .nmi_out(nmi), .interrupt_return_instruction_out(interrupt_return_instruction));
    task automatic bus(input logic w, input logic [5:0] idx, input logic [15:0] wd_v,
                       output logic [15:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h00_0000, idx, 2'h0};
        // Address phase stands until ready is seen high at an edge
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, wd_v};
        // Data phase ends at the edge where ready is high again
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata[15:0];
        `CHK(hresp, 1'b0)
    endtask : bus
    task automatic wr(input logic [5:0] idx, input logic [15:0] v);
        logic [15:0] d;
        bus(1'b1, idx, v, d);
    endtask : wr
    task automatic chk_rd(input logic [5:0] idx, input logic [15:0] e);
        logic [15:0] d;
        bus(1'b0, idx, 16'h0000, d);
        `CHK(d, e)
    endtask : chk_rd
    task automatic t_reset;
        chk_rd(IDX_TCU, 16'h000f);
        chk_rd(IDX_DMA0, 16'h000f);
        chk_rd(IDX_DMA1, 16'h000f);
        chk_rd(IDX_MASK, 16'h000d);
        chk_rd(IDX_T1, 16'h0000);
        chk_rd(6'h3c, 16'h0000);
        `CHK(src_prio, 15'h7fff)
        `CHK(susp, 1'b0)
    endtask : t_reset
    task automatic t_ctrl;
        wr(IDX_TCU, 16'hfff2);
        chk_rd(IDX_TCU, 16'h0002);
        `CHK(src_prio[2:0], 3'h2)
        chk_rd(IDX_MASK, 16'h000c);
        wr(IDX_MASK, 16'h0001);
        chk_rd(IDX_TCU, 16'h000a);
        chk_rd(IDX_DMA0, 16'h0007);
    endtask : t_ctrl
    task automatic t_timer;
        wr(IDX_TCU, 16'h0002);
        core.pulse(3'h2, 1'b0, 1'b0);
        chk_rd(IDX_STATUS, 16'h0002);
        chk_rd(IDX_REQUEST, 16'h0001);
        `CHK(vec, 8'h12)
        `CHK(irq_prio, 3'h2)
        core.pulse(3'h1, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        `CHK(vec, 8'h08)
        wr(IDX_TCU, 16'h000a);
        repeat (3) @(posedge clk);
        `CHK(src_req[0], 1'b0)
        `CHK(irq_valid, 1'b0)
        wr(IDX_TCU, 16'h0002);
        ack_en <= 1'b1;
        repeat (30) @(posedge clk);
        ack_en <= 1'b0;
        chk_rd(IDX_STATUS, 16'h0000);
    endtask : t_timer
    task automatic t_dma;
        pin_irq <= 2'h3;
        pin <= 2'h3;
        wr(IDX_DMA0, 16'h0001);
        wr(IDX_DMA1, 16'h0000);
        repeat (3) @(posedge clk);
        `CHK(vec, 8'h0b)
        wr(IDX_DMA1, 16'h0008);
        repeat (3) @(posedge clk);
        `CHK(vec, 8'h0a)
        pin_irq <= 2'h0;
        pin <= 2'h1;
        wr(IDX_TCU, 16'h000a);
        `CHK(dma_req, 2'h1)
        core.pulse(3'h0, 1'b1, 1'b0);
        chk_rd(IDX_STATUS, 16'h8000);
        `CHK(dma_req, 2'h0)
        core.pulse(3'h0, 1'b0, 1'b1);
        @(posedge clk);
        `CHK(susp, 1'b0)
        wr(IDX_STATUS, 16'h8000);
        // Write lands on the closing edge of its data phase
        @(posedge clk);
        `CHK(susp, 1'b1)
        wr(IDX_STATUS, 16'h0000);
        @(posedge clk);
        `CHK(dma_req, 2'h1)
        pin <= 2'h0;
    endtask : t_dma
    task automatic t_request;
        pin_irq <= 2'h1;
        pin <= 2'h1;
        dma_done <= 2'h2;
        ser_en <= 1'b1;
        ser <= 6'h20;
        wd <= 1'b1;
        ext <= 5'h15;
        chk_rd(IDX_REQUEST, 16'h075c);
        ser_en <= 1'b0;
        wr(IDX_REQUEST, 16'hffff);
        chk_rd(IDX_REQUEST, 16'h035c);
        {pin, dma_done, ser, wd, ext} <= '0;
    endtask : t_request
    task automatic t_slave;
        slave <= 1'b1;
        wr(IDX_T1, 16'h0001);
        wr(IDX_T2, 16'hfff0);
        chk_rd(IDX_T2, 16'h0000);
        chk_rd(IDX_DMA1, 16'h0008);
        chk_rd(IDX_MASK, 16'h0009);
        core.pulse(3'h6, 1'b0, 1'b0);
        repeat (3) @(posedge clk);
        `CHK(src_req, 5'h18)
        `CHK(vec, 8'h13)
        `CHK(irq_prio, 3'h0)
        ack_en <= 1'b1;
        repeat (30) @(posedge clk);
        ack_en <= 1'b0;
        chk_rd(IDX_STATUS, 16'h0000);
        slave <= 1'b0;
    endtask : t_slave
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_ctrl();
        t_timer();
        t_dma();
        t_request();
        t_slave();
        tally_and_finish();
    end
    initial
    begin
        #(100 * 5000);
        mismatches++;
        tally_and_finish();
    end
endmodule : tiq_irq_ctrl_test

// file: core/tiq_ahb_slave.sv
// AHB-Lite slave front end, one wait state on reads
`timescale 1ns/10ps
module tiq_ahb_slave
    import tiq_pkg::*;
(
    input wire logic clk_sys_in, // System clock
    input wire logic nrst_in, // Sync reset, active low
    input wire logic hsel_in, // Slave select
    input wire logic [31:0] haddr_in, // Byte address
    input wire logic [1:0] htrans_in, // Transfer type
    input wire logic hwrite_in, // Write when high
    input wire logic hready_in, // Bus ready
    input wire logic [31:0] hwdata_in, // Write data
    output logic [31:0] hrdata_out, // Read data
    output logic hreadyout_out, // Slave ready
    tiq_reg_if.bus rb // Register side
);
    tiq_bus_st_e st_q;
    logic [5:0] idx_q;
    logic ok_q;
    logic [31:0] hrdata_q;
    logic accept;

    assign accept = hsel_in && htrans_in[1] && hready_in;
    assign hreadyout_out = (st_q != ST_RD_WAIT);
    assign hrdata_out = hrdata_q;
    assign rb.idx = idx_q;
    assign rb.wdata = hwdata_in[DATA_W-1:0];
    assign rb.wr_en = (st_q == ST_WR) && ok_q;

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
            st_q <= ST_IDLE;
        else if (st_q == ST_RD_WAIT)
            st_q <= ST_RD_DONE;
        else if (accept)
            st_q <= hwrite_in ? ST_WR : ST_RD_WAIT;
        else
            st_q <= ST_IDLE;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            idx_q <= 6'h00;
            ok_q <= 1'b0;
        end
        else if (accept)
        begin
            idx_q <= haddr_in[IDX_LSB +: IDX_W];
            ok_q <= (haddr_in[31:8] == 24'h00_0000) && (haddr_in[1:0] == 2'h0);
        end
    end

    // Read data sampled after any write in flight has landed
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
            hrdata_q <= 32'h0000_0000;
        else if (st_q == ST_RD_WAIT)
            hrdata_q <= ok_q ? {16'h0000, rb.rdata} : 32'h0000_0000;
    end

    sequence rd_taken_s;
        accept && !hwrite_in;
    endsequence
    sequence rd_answer_s;
        !hreadyout_out ##1 hreadyout_out;
    endsequence
    read_wait_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        rd_taken_s |=> rd_answer_s) else $error("read answer not after one wait");
endmodule : tiq_ahb_slave

// file: core/tiq_irq_ctrl.sv
// Timer and DMA interrupt control, status and request registers
//
// Contract
// - Master mode: timers use vectors 08h, 12h, 13h under one unit register.
// - Control bit 3 is the mask: 0 lets the source interrupt, 1 blocks.
// - Bits 2:0 hold the source priority; reset value 7, the lowest.
// - Control mask bits and mask register bits always show the same value.
// - Slave mode: timers 2, 1, 0 own registers at 03ah, 038h, 032h.
// - DMA channel 0 and 1 sources use vectors 0ah and 0bh.
// - Each shared pin is an interrupt or DMA request, chosen outside.
// - Slave mode keeps both DMA control registers at the same addresses.
// - Every control register resets to 000Fh.
// - While status bit 15 is set, all DMA transfers are held off.
// - Halt bit sets on a non-maskable interrupt, clears on interrupt return.
// - Status bits 2:0 show pending requests of timers 2, 1, 0.
// - Request bit 0 is the OR of the three timer pending bits in master mode, timer 0 alone in slave mode.
// - Request register is read-only and shows live request lines.
// - Request bit 10, when enabled, ORs the six serial port sources; the code does so in master mode only, bit 10 reads 0 in slave mode.
// - Request bit 9 reads 1 while a watchdog request is pending; the code does so in master mode only, bit 9 reads 0 in slave mode.
// - Master mode: request bits 8:4 are external lines 4:0; slave mode: bits 5:4 are timers 2, 1; bits 3:2 DMA channels.
// - Priority encodes 0 as 000b up to 7 as 111b, lower wins.
// - Writing the mask register equals writing the control mask bits.
`timescale 1ns/10ps
module tiq_irq_ctrl
    import tiq_pkg::*;
(
    input wire logic clk_sys_in, // System clock, 10 MHz
    input wire logic nrst_in, // Sync reset, active low
    input wire logic hsel_in, // AHB select
    input wire logic [31:0] haddr_in, // AHB address
    input wire logic [1:0] htrans_in, // AHB transfer type
    input wire logic hwrite_in, // AHB write
    input wire logic [2:0] hsize_in, // AHB size, words only
    input wire logic hready_in, // AHB ready
    input wire logic [31:0] hwdata_in, // AHB write data
    output logic [31:0] hrdata_out, // AHB read data
    output logic hreadyout_out, // AHB slave ready
    output logic hresp_out, // AHB response, always OKAY
    input wire logic slave_mode_in, // High selects slave mode map
    input wire logic [2:0] timer_event_in, // Timer 2..0 interrupt pulse
    input wire logic [2:0] timer_ack_in, // Timer 2..0 acknowledge pulse
    input wire logic nmi_in, // Non-maskable interrupt pulse
    input wire logic interrupt_return_instruction_in, // Interrupt return executed pulse
    input wire logic [1:0] shared_pin_in, // DMA/interrupt shared pins
    input wire logic [1:0] pin_is_irq_in, // High: pin is interrupt input
    input wire logic [1:0] dma_done_in, // DMA channel interrupt level
    input wire logic serial_irq_enable_in, // Serial port request enable
    input wire logic [5:0] serial_src_in, // Serial port source levels
    input wire logic watchdog_req_in, // Watchdog request level
    input wire logic [4:0] ext_line_req_in, // External lines 4..0 level
    output logic [1:0] dma_request_out, // DMA requests to channels
    output logic dma_suspend_out, // DMA halted
    output logic [4:0] src_req_out, // Per-source request to core
    output logic [14:0] src_prio_out, // Per-source priority, 3 bits each
    output logic irq_valid_out, // Winning request present
    output logic [7:0] irq_vector_out, // Winning vector type
    output logic [2:0] irq_prio_out // Winning priority
);
    tiq_reg_if rb ();

    logic [2:0] per_timer_pending_q;
    logic dma_suspend_flag_q;
    logic [NSRC-1:0] source_mask_bit;
    logic [PRIO_W-1:0] source_priority_field [NSRC];
    logic [NSRC-1:0] src_mapped;
    logic [NSRC-1:0] src_pend;
    logic [NSRC-1:0] src_req;
    logic [NSRC-1:0] mask_wr;
    logic [1:0] dma_channel_requests;
    logic timer_unit_pending;
    logic serial_port_request;
    logic sts_wr;
    logic [15:0] req_word;
    logic [15:0] mask_word;
    logic [15:0] sts_word;
    logic [2:0] per_timer_pending_d;
    logic dma_suspend_flag_d;
    logic win_valid;
    logic [7:0] win_vec;
    logic [2:0] win_prio;
    logic irq_valid_q;
    logic [7:0] irq_vector_q;
    logic [2:0] irq_prio_q;
    logic [4:0] src_req_q;

    assign hresp_out = 1'b0;

    tiq_ahb_slave u_bus (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .hsel_in(hsel_in),
        .haddr_in(haddr_in),
        .htrans_in(htrans_in),
        .hwrite_in(hwrite_in),
        .hready_in(hready_in),
        .hwdata_in(hwdata_in),
        .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out),
        .rb(rb.bus)
    );

    // Timer 1 and 2 registers exist only in slave mode; dma ones in both
    assign src_mapped = slave_mode_in ? 5'h1f : MASTER_SRC_MAP;

    genvar g;
    generate
        for (g = 0; g < NSRC; g++)
        begin : g_src
            // Mask register bit drives the same flop as the control bit
            assign mask_wr[g] = rb.wr_en && (rb.idx == IDX_MASK) && src_mapped[g];
            tiq_src_ctrl #(
                .REG_IDX(SRC_IDX[g])
            ) u_ctrl (
                .clk_sys_in(clk_sys_in),
                .nrst_in(nrst_in),
                .rb(rb.fld),
                .mapped_in(src_mapped[g]),
                .mask_wr_in(mask_wr[g]),
                .mask_val_in(rb.wdata[SRC_MASK_POS[g]]),
                .mask_out(source_mask_bit[g]),
                .prio_out(source_priority_field[g])
            );
            assign src_prio_out[g*PRIO_W +: PRIO_W] = source_priority_field[g];
        end
    endgenerate

    // Shared pin either raises the channel's interrupt or requests DMA
    assign dma_channel_requests = (pin_is_irq_in & shared_pin_in)
        | (~pin_is_irq_in & dma_done_in);
    assign dma_request_out = (~pin_is_irq_in & shared_pin_in)
        & {2{~dma_suspend_flag_q}};
    assign dma_suspend_out = dma_suspend_flag_q;

    assign sts_wr = rb.wr_en && (rb.idx == IDX_STATUS);

    // A timer event in the cycle of a clear or a write still lands
    always_comb
    begin
        per_timer_pending_d = per_timer_pending_q & ~timer_ack_in;
        if (sts_wr)
            per_timer_pending_d = rb.wdata[STS_TMR_LSB +: NTIMER];
        per_timer_pending_d = per_timer_pending_d | timer_event_in;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
            per_timer_pending_q <= 3'h0;
        else
            per_timer_pending_q <= per_timer_pending_d;
    end

    // Non-maskable event beats software write, which beats return
    always_comb
    begin
        dma_suspend_flag_d = dma_suspend_flag_q;
        if (interrupt_return_instruction_in)
            dma_suspend_flag_d = 1'b0;
        if (sts_wr)
            dma_suspend_flag_d = rb.wdata[STS_SUSPEND_BIT];
        if (nmi_in)
            dma_suspend_flag_d = 1'b1;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
            dma_suspend_flag_q <= 1'b0;
        else
            dma_suspend_flag_q <= dma_suspend_flag_d;
    end

    assign timer_unit_pending = |per_timer_pending_q;
    assign serial_port_request = serial_irq_enable_in && (|serial_src_in);

    // Master mode folds all timers onto the unit source
    always_comb
    begin
        src_pend = 5'h00;
        src_pend[SRC_D0] = dma_channel_requests[0];
        src_pend[SRC_D1] = dma_channel_requests[1];
        if (slave_mode_in)
        begin
            src_pend[SRC_T0] = per_timer_pending_q[0];
            src_pend[SRC_T1] = per_timer_pending_q[1];
            src_pend[SRC_T2] = per_timer_pending_q[2];
        end
        else
            src_pend[SRC_T0] = timer_unit_pending;
    end

    assign src_req = src_pend & ~source_mask_bit & src_mapped;

    // Lowest priority code wins; ties go to the lower source number
    always_comb
    begin
        win_valid = 1'b0;
        win_vec = 8'h00;
        win_prio = 3'h7;
        for (int i = 0; i < NSRC; i++)
        begin
            if (src_req[i] && (!win_valid || (source_priority_field[i] < win_prio)))
            begin
                win_valid = 1'b1;
                win_prio = source_priority_field[i];
                win_vec = SRC_VEC[i];
            end
        end
        // Unit source in master mode names the lowest pending timer
        if (!slave_mode_in && win_valid && (win_vec == SRC_VEC[SRC_T0]))
        begin
            if (!per_timer_pending_q[0] && per_timer_pending_q[1])
                win_vec = SRC_VEC[SRC_T1];
            else if (!per_timer_pending_q[0])
                win_vec = SRC_VEC[SRC_T2];
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            irq_valid_q <= 1'b0;
            irq_vector_q <= 8'h00;
            irq_prio_q <= 3'h7;
            src_req_q <= 5'h00;
        end
        else
        begin
            irq_valid_q <= win_valid;
            irq_vector_q <= win_vec;
            irq_prio_q <= win_prio;
            src_req_q <= src_req;
        end
    end

    assign irq_valid_out = irq_valid_q;
    assign irq_vector_out = irq_vector_q;
    assign irq_prio_out = irq_prio_q;
    assign src_req_out = src_req_q;

    // Live request lines; no storage so nothing to reset
    always_comb
    begin
        req_word = 16'h0000;
        req_word[REQ_DMA_LSB +: 2] = dma_channel_requests;
        if (slave_mode_in)
        begin
            req_word[REQ_TMR_BIT] = per_timer_pending_q[0];
            req_word[REQ_S_T1_BIT] = per_timer_pending_q[1];
            req_word[REQ_S_T2_BIT] = per_timer_pending_q[2];
        end
        else
        begin
            req_word[REQ_TMR_BIT] = timer_unit_pending;
            req_word[REQ_SERIAL_BIT] = serial_port_request;
            req_word[REQ_WD_BIT] = watchdog_req_in;
            req_word[REQ_EXT_LSB +: NEXT] = ext_line_req_in;
        end
    end

    // Mask register view reads the very flops the control registers hold
    always_comb
    begin
        mask_word = 16'h0000;
        for (int i = 0; i < NSRC; i++)
        begin
            if (src_mapped[i])
                mask_word[SRC_MASK_POS[i]] = source_mask_bit[i];
        end
    end

    always_comb
    begin
        sts_word = 16'h0000;
        sts_word[STS_SUSPEND_BIT] = dma_suspend_flag_q;
        sts_word[STS_TMR_LSB +: NTIMER] = per_timer_pending_q;
    end

    // Unknown indices and registers of the other mode read zero
    always_comb
    begin
        rb.rdata = 16'h0000;
        if (rb.idx == IDX_REQUEST)
            rb.rdata = req_word;
        else if (rb.idx == IDX_MASK)
            rb.rdata = mask_word;
        else if (rb.idx == IDX_STATUS)
            rb.rdata = sts_word;
        else
        begin
            for (int i = 0; i < NSRC; i++)
            begin
                if ((rb.idx == SRC_IDX[i]) && src_mapped[i])
                    rb.rdata = {12'h000, source_mask_bit[i], source_priority_field[i]};
            end
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);

    sequence mask_write_s;
        rb.wr_en && (rb.idx == IDX_MASK);
    endsequence
    sequence status_write_s;
        rb.wr_en && (rb.idx == IDX_STATUS);
    endsequence

    ctrl_reset_val_a: assert property (disable iff (1'b0) !nrst_in ##1 nrst_in |->
        (source_mask_bit == 5'h1f) && (src_prio_out == 15'h7fff))
        else $error("control registers not at reset value");
    mask_gate_a: assert property (##1 ((src_req_out & $past(source_mask_bit)) == 5'h00))
        else $error("masked source requested");
    mask_mirror_a: assert property (mask_write_s ##0 !sts_wr |=>
        source_mask_bit[SRC_D0] == $past(rb.wdata[SRC_MASK_POS[SRC_D0]]))
        else $error("mask register write not mirrored");
    halt_nmi_a: assert property (nmi_in |=> dma_suspend_out[*2] or (dma_suspend_out ##1
        ($past(interrupt_return_instruction_in) || $past(sts_wr)))) else $error("halt not set by nmi");
    halt_interrupt_return_instruction_a: assert property (interrupt_return_instruction_in && !nmi_in && !sts_wr |=> !dma_suspend_out)
        else $error("halt not cleared by return");
    dma_hold_a: assert property (dma_suspend_out |-> dma_request_out == 2'h0)
        else $error("dma request while halted");
    timer_pend_a: assert property (timer_event_in[0] |=> per_timer_pending_q[0]
        ##0 (status_write_s or 1'b1)) else $error("timer event lost");
    timer_or_a: assert property (!slave_mode_in |->
        req_word[REQ_TMR_BIT] == (|per_timer_pending_q)) else $error("timer or wrong");
    winner_a: assert property (|src_req |=> irq_valid_out ##0
        (irq_prio_out <= $past(source_priority_field[SRC_D0]) || !$past(src_req[SRC_D0])))
        else $error("winner not ranked");
    no_winner_a: assert property (src_req == 5'h00 |=> !irq_valid_out)
        else $error("request without source");
endmodule : tiq_irq_ctrl

// file: core/tiq_pkg.sv
// Constants shared by the timer and DMA interrupt control block
package tiq_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_MASK = 6'h28;
    localparam logic [5:0] IDX_REQUEST = 6'h2e;
    localparam logic [5:0] IDX_STATUS = 6'h30;
    localparam logic [5:0] IDX_TCU = 6'h32;
    localparam logic [5:0] IDX_DMA0 = 6'h34;
    localparam logic [5:0] IDX_DMA1 = 6'h36;
    localparam logic [5:0] IDX_T1 = 6'h38;
    localparam logic [5:0] IDX_T2 = 6'h3a;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 6;
    localparam int DATA_W = 16;
    // Control register layout and reset
    localparam logic [15:0] CTRL_RESET = 16'h000f;
    localparam int MASK_BIT = 3;
    localparam int PRIO_W = 3;
    localparam int PRIO_LSB = 0;
    // Status register layout
    localparam int STS_SUSPEND_BIT = 15;
    localparam int STS_TMR_LSB = 0;
    localparam int NTIMER = 3;
    // Request register layout, also used by the mask register
    localparam int REQ_SERIAL_BIT = 10;
    localparam int REQ_WD_BIT = 9;
    localparam int REQ_EXT_LSB = 4;
    localparam int NEXT = 5;
    localparam int REQ_DMA_LSB = 2;
    localparam int REQ_TMR_BIT = 0;
    localparam int REQ_S_T1_BIT = 4;
    localparam int REQ_S_T2_BIT = 5;
    localparam int NSERIAL = 6;
    // Sources: timer unit or timer 0, dma 0, dma 1, timer 1, timer 2
    localparam int NSRC = 5;
    localparam int SRC_T0 = 0;
    localparam int SRC_D0 = 1;
    localparam int SRC_D1 = 2;
    localparam int SRC_T1 = 3;
    localparam int SRC_T2 = 4;
    localparam logic [4:0] MASTER_SRC_MAP = 5'h07;
    localparam logic [5:0] SRC_IDX [NSRC] = '{IDX_TCU, IDX_DMA0, IDX_DMA1, IDX_T1, IDX_T2};
    localparam int SRC_MASK_POS [NSRC] = '{0, 2, 3, 4, 5};
    localparam logic [7:0] SRC_VEC [NSRC] = '{8'h08, 8'h0a, 8'h0b, 8'h12, 8'h13};
    typedef enum logic [1:0] {ST_IDLE, ST_WR, ST_RD_WAIT, ST_RD_DONE} tiq_bus_st_e;
endpackage : tiq_pkg

// file: core/tiq_reg_if.sv
// Register access carrier between bus slave and register logic
`timescale 1ns/10ps
interface tiq_reg_if;
    logic wr_en;
    logic [5:0] idx;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport bus (output wr_en, output idx, output wdata, input rdata);
    modport regs (input wr_en, input idx, input wdata, output rdata);
    modport fld (input wr_en, input idx, input wdata);
endinterface : tiq_reg_if

// file: core/tiq_src_ctrl.sv
// One source control register: mask bit and priority field
`timescale 1ns/10ps
module tiq_src_ctrl
    import tiq_pkg::*;
#(
    parameter logic [5:0] REG_IDX = IDX_TCU
)
(
    input wire logic clk_sys_in, // System clock
    input wire logic nrst_in, // Sync reset, active low
    tiq_reg_if.fld rb, // Register writes
    input wire logic mapped_in, // Register visible in this mode
    input wire logic mask_wr_in, // Mask register write hits this source
    input wire logic mask_val_in, // Mask value from mask register
    output logic mask_out, // Source blocked when high
    output logic [2:0] prio_out // Priority, 0 highest
);
    always_ff @(posedge clk_sys_in)
    begin
        if (!nrst_in)
        begin
            mask_out <= CTRL_RESET[MASK_BIT];
            prio_out <= CTRL_RESET[PRIO_LSB +: PRIO_W];
        end
        else if (rb.wr_en && (rb.idx == REG_IDX) && mapped_in)
        begin
            mask_out <= rb.wdata[MASK_BIT];
            prio_out <= rb.wdata[PRIO_LSB +: PRIO_W];
        end
        else if (mask_wr_in)
            mask_out <= mask_val_in;
    end
endmodule : tiq_src_ctrl
